// [main_timer.v]
// 18-bit timer/counter: timer, event, pulse width and frequency modes
`timescale 1ns/1ps
`default_nettype none
`include "main_timer_consts.vh"

// Contract
// - Timer mode counts internal source ticks
// - Compare match raises irq, clears, restarts
// - Seven internal taps, slow taps from fs
// - Fc in slow mode matches upper seven bits
// - Timer mode serves as warm-up timer
// - Event mode counts external falling edges
// - Pulse width counts falls of window AND clock
// - Pulse width irq on fall or both edges
// - Uncleared counter resumes from stopped value
// - Wrap sets overflow until counter clear
// - Stop write with window high raises irq
// - Start write, both edges, window high: irq
// - Status flag invalid in pulse width mode
// - Window fall with clock high adds one
// - Frequency mode counts edges while gate high
// - Gate select 00 picks external gate pin
// - Frequency irq on gate fall or both
// - Status flag follows gate counting state
// - Block bit gates other timer to pin
// - Internal gate high/low from settings, fc
// - Slow gate clock taps from fs
// - Start 00 stops and clears, 10 runs
// - Status reads zero stopped, one counting
// - Low setting applies next low; late start
// - Low compare byte write inhibits matches
module main_timer #(
  parameter FC_DIV_W = 23,
  parameter FS_DIV_W = 15
) (
  // Clock and reset
  input  wire        clock_i,
  input  wire        rstn_i,
  // Power mode and low-frequency clock enable
  input  wire        slow_mode_i,
  input  wire        divider_source_bit_i,
  input  wire        fs_tick_i,
  // Control fields
  input  wire [1:0]  start_control_i,
  input  wire [1:0]  mode_select_i,
  input  wire [2:0]  source_clock_select_i,
  input  wire        counter_clear_i,
  input  wire        irq_edge_select_i,
  input  wire [1:0]  gate_source_select_i,
  input  wire [1:0]  gate_clock_select_i,
  input  wire        other_timer_out_block_i,
  input  wire [3:0]  gate_high_setting_i,
  input  wire [3:0]  gate_low_setting_i,
  // Compare register byte writes
  input  wire [7:0]  cmp_wdata_i,
  input  wire        cmp_wr_low_i,
  input  wire        cmp_wr_mid_i,
  input  wire        cmp_wr_high_i,
  // External pins and other timer
  input  wire        ext_count_input_i,
  input  wire        ext_gate_input_i,
  input  wire        other_timer_out_i,
  // Results
  output reg  [17:0] count_o,
  output reg         timer_irq_o,
  output reg         overflow_flag_o,
  output reg         counting_status_flag_o,
  output reg         shared_output_pin_o
);

  reg [FC_DIV_W-1:0] fc_div_reg;
  reg [FS_DIV_W-1:0] fs_div_reg;
  reg [17:0]         cmp_reg;
  reg                inhibit_reg;
  reg [1:0]          start_prev_reg;
  reg                ext_count_input_prev_reg;
  reg                and_prev_reg;
  reg                fand_prev_reg;
  reg                gate_prev_reg;
  reg [1:0]          gen_state_reg;
  reg [4:0]          gen_cnt_reg;
  reg                src_pulse;
  reg                src_level;
  reg                src_direct;
  reg                gate_tick;
  reg                gate_sel;

  wire alt_src  = divider_source_bit_i | slow_mode_i;
  wire running  = (start_control_i == `START_RUN);
  wire stopping = (start_control_i == `START_STOP);
  wire tc_mode  = (mode_select_i == `MODE_TIMER_EVENT);
  wire pw_mode  = (mode_select_i == `MODE_PULSE_WIDTH);
  wire fm_mode  = (mode_select_i == `MODE_FREQ_MEAS);
  wire ext_src  = (source_clock_select_i == `SRC_EXTERNAL);
  wire ext_count_input     = ext_count_input_i;
  wire ext_count_input_fall = ext_count_input_prev_reg & ~ext_count_input;
  wire ext_count_input_rise = ~ext_count_input_prev_reg & ext_count_input;

  // Prescaler taps: one-cycle pulse when the low bits roll over
  wire fc_p3  = &fc_div_reg[2:0];
  wire fc_p7  = &fc_div_reg[6:0];
  wire fc_p11 = &fc_div_reg[10:0];
  wire fc_p12 = &fc_div_reg[11:0];
  wire fc_p13 = &fc_div_reg[12:0];
  wire fc_p14 = &fc_div_reg[13:0];
  wire fc_p23 = &fc_div_reg[22:0];
  wire fs_p3  = fs_tick_i & (&fs_div_reg[2:0]);
  wire fs_p4  = fs_tick_i & (&fs_div_reg[3:0]);
  wire fs_p5  = fs_tick_i & (&fs_div_reg[4:0]);
  wire fs_p6  = fs_tick_i & (&fs_div_reg[5:0]);
  wire fs_p15 = fs_tick_i & (&fs_div_reg[14:0]);

  // Source clock choice as pulse plus square-wave level
  always @* begin
    src_direct = 1'b0;
    case (source_clock_select_i)
      `SRC_FC: begin
        src_pulse  = 1'b1;
        src_level  = 1'b1;
        src_direct = 1'b1;
      end
      `SRC_FS: begin
        src_pulse  = fs_tick_i;
        src_level  = 1'b1;
        src_direct = 1'b1;
      end
      `SRC_TAP_A: begin
        src_pulse = alt_src ? fs_p15 : fc_p23;
        src_level = alt_src ? fs_div_reg[14] : fc_div_reg[22];
      end
      `SRC_TAP_B: begin
        src_pulse = alt_src ? fs_p5 : fc_p13;
        src_level = alt_src ? fs_div_reg[4] : fc_div_reg[12];
      end
      `SRC_TAP_C: begin
        src_pulse = alt_src ? fs_p3 : fc_p11;
        src_level = alt_src ? fs_div_reg[2] : fc_div_reg[10];
      end
      `SRC_FC_DIV7: begin
        src_pulse = fc_p7;
        src_level = fc_div_reg[6];
      end
      `SRC_FC_DIV3: begin
        src_pulse = fc_p3;
        src_level = fc_div_reg[2];
      end
      default: begin
        src_pulse = 1'b0;
        src_level = 1'b0;
      end
    endcase
  end

  // Gate clock for the internal window generator
  always @* begin
    case (gate_clock_select_i)
      `GCLK_SEL0: gate_tick = alt_src ? fs_p4 : fc_p12;
      `GCLK_SEL1: gate_tick = alt_src ? fs_p5 : fc_p13;
      `GCLK_SEL2: gate_tick = alt_src ? fs_p6 : fc_p14;
      default:    gate_tick = 1'b0;
    endcase
  end

  wire gen_gate = (gen_state_reg == `GEN_HIGH);

  always @* begin
    case (gate_source_select_i)
      `GATE_EXT_PIN:  gate_sel = ext_gate_input_i;
      `GATE_INTERNAL: gate_sel = gen_gate;
      default:        gate_sel = other_timer_out_i;
    endcase
  end

  wire gate_fall = gate_prev_reg & ~gate_sel;
  wire gate_rise = ~gate_prev_reg & gate_sel;

  // Falling edges of the AND-ed signals; a window fall while the
  // clock is high also produces one, giving the extra count
  wire and_now  = ext_count_input & src_level;
  wire fand_now = ext_count_input & gate_sel;
  wire pw_count = src_direct ? (ext_count_input & src_pulse)
                             : (and_prev_reg & ~and_now);
  wire fm_count = fand_prev_reg & ~fand_now;

  reg count_en;
  always @* begin
    count_en = 1'b0;
    if (running) begin
      if (tc_mode && !ext_src)
        count_en = src_pulse;
      else if (tc_mode)
        count_en = ext_count_input_fall;
      else if (pw_mode)
        count_en = pw_count;
      else if (fm_mode)
        count_en = fm_count;
    end
  end

  // Fc in slow mode compares the upper bits only
  wire        fc_slow   = slow_mode_i && (source_clock_select_i == `SRC_FC);
  wire [17:0] cmp_mask  = fc_slow ? `MASK_UPPER7 : `MASK_FULL;
  wire [17:0] count_inc = count_o + 18'h00001;
  wire        match     = tc_mode && !inhibit_reg
                          && ((count_inc & cmp_mask) == (cmp_reg & cmp_mask));
  wire        wrap      = count_en && !match && (count_o == `COUNT_MAX);

  // Write-edge detection on the start field
  wire stop_write  = (start_prev_reg == `START_RUN) && stopping;
  wire start_write = (start_prev_reg != `START_RUN) && running;

  reg irq_next;
  always @* begin
    irq_next = 1'b0;
    if (tc_mode)
      irq_next = count_en && match;
    else if (pw_mode) begin
      if (running && (ext_count_input_fall || (irq_edge_select_i && ext_count_input_rise)))
        irq_next = 1'b1;
      if (stop_write && ext_count_input)
        irq_next = 1'b1;
      if (start_write && ext_count_input && irq_edge_select_i)
        irq_next = 1'b1;
    end else if (fm_mode) begin
      if (running && (gate_fall || (irq_edge_select_i && gate_rise)))
        irq_next = 1'b1;
    end
  end

  // Internal window gate generator
  wire       gen_on    = running && fm_mode && (gate_source_select_i == `GATE_INTERNAL);
  wire [4:0] high_len  = `GATE_PERIOD_BASE - {1'b0, gate_high_setting_i};
  wire [4:0] low_len   = `GATE_PERIOD_BASE - {1'b0, gate_low_setting_i};
  reg  [1:0] gen_state_next;
  reg  [4:0] gen_cnt_next;

  always @* begin
    gen_state_next = gen_state_reg;
    gen_cnt_next   = gen_cnt_reg;
    case (gen_state_reg)
      `GEN_IDLE: begin
        if (gen_on)
          gen_state_next = `GEN_WAIT;
      end
      `GEN_WAIT: begin
        // Aligned to the divider, so high may start one gate clock late
        if (gate_tick) begin
          gen_state_next = `GEN_HIGH;
          gen_cnt_next   = high_len;
        end
      end
      `GEN_HIGH: begin
        if (gate_tick) begin
          if (gen_cnt_reg == 5'h01) begin
            gen_state_next = `GEN_LOW;
            gen_cnt_next   = low_len;
          end else
            gen_cnt_next = gen_cnt_reg - 5'h01;
        end
      end
      `GEN_LOW: begin
        if (gate_tick) begin
          if (gen_cnt_reg == 5'h01) begin
            gen_state_next = `GEN_HIGH;
            gen_cnt_next   = high_len;
          end else
            gen_cnt_next = gen_cnt_reg - 5'h01;
        end
      end
      default: gen_state_next = `GEN_IDLE;
    endcase
    if (!gen_on)
      gen_state_next = `GEN_IDLE;
  end

  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fc_div_reg             <= {FC_DIV_W{1'b0}};
      fs_div_reg             <= {FS_DIV_W{1'b0}};
      cmp_reg                <= `COUNT_ZERO;
      inhibit_reg            <= 1'b0;
      start_prev_reg         <= `START_STOP;
      ext_count_input_prev_reg          <= 1'b0;
      and_prev_reg           <= 1'b0;
      fand_prev_reg          <= 1'b0;
      gate_prev_reg          <= 1'b0;
      gen_state_reg          <= `GEN_IDLE;
      gen_cnt_reg            <= 5'h00;
      count_o                <= `COUNT_ZERO;
      timer_irq_o            <= 1'b0;
      overflow_flag_o        <= 1'b0;
      counting_status_flag_o <= 1'b0;
      shared_output_pin_o    <= 1'b0;
    end else begin
      fc_div_reg <= fc_div_reg + {{(FC_DIV_W-1){1'b0}}, 1'b1};
      if (fs_tick_i)
        fs_div_reg <= fs_div_reg + {{(FS_DIV_W-1){1'b0}}, 1'b1};
      start_prev_reg <= start_control_i;
      ext_count_input_prev_reg  <= ext_count_input;
      and_prev_reg   <= and_now;
      fand_prev_reg  <= fand_now;
      gate_prev_reg  <= gate_sel;
      gen_state_reg  <= gen_state_next;
      gen_cnt_reg    <= gen_cnt_next;

      // Compare register loads bytewise; low bytes inhibit matching
      if (cmp_wr_low_i)
        cmp_reg[7:0] <= cmp_wdata_i;
      if (cmp_wr_mid_i)
        cmp_reg[15:8] <= cmp_wdata_i;
      if (cmp_wr_high_i)
        cmp_reg[17:16] <= cmp_wdata_i[1:0];
      if (cmp_wr_high_i)
        inhibit_reg <= 1'b0;
      else if (cmp_wr_low_i || cmp_wr_mid_i)
        inhibit_reg <= 1'b1;

      // Counter is held, not cleared, between windows
      if (counter_clear_i || stopping)
        count_o <= `COUNT_ZERO;
      else if (count_en)
        count_o <= match ? `COUNT_ZERO : count_inc;

      // Overflow set wins over a same-cycle clear
      overflow_flag_o <= wrap || (overflow_flag_o && !counter_clear_i);

      timer_irq_o <= irq_next;

      // Pulse width mode gives no status; reads zero there
      counting_status_flag_o <= running && fm_mode && gate_sel;

      shared_output_pin_o <= !other_timer_out_block_i && other_timer_out_i;
    end
  end

endmodule // main_timer
`default_nettype wire

// [main_timer_consts.vh]
// Constants for the 18-bit multimode timer/counter
`ifndef MAIN_TIMER_CONSTS_VH
`define MAIN_TIMER_CONSTS_VH

// Start control codes
`define START_STOP        2'h0
`define START_RUN         2'h2

// Operating modes
`define MODE_TIMER_EVENT  2'h0
`define MODE_PULSE_WIDTH  2'h2
`define MODE_FREQ_MEAS    2'h3

// Source clock select codes
`define SRC_FC            3'h0
`define SRC_FS            3'h1
`define SRC_TAP_A         3'h2
`define SRC_TAP_B         3'h3
`define SRC_TAP_C         3'h4
`define SRC_FC_DIV7       3'h5
`define SRC_FC_DIV3       3'h6
`define SRC_EXTERNAL      3'h7

// Window gate source codes
`define GATE_EXT_PIN      2'h0
`define GATE_INTERNAL     2'h1

// Gate clock select codes
`define GCLK_SEL0         2'h0
`define GCLK_SEL1         2'h1
`define GCLK_SEL2         2'h2

// Counter limits and masks
`define COUNT_MAX         18'h3ffff
`define COUNT_ZERO        18'h00000
`define MASK_FULL         18'h3ffff
`define MASK_UPPER7       18'h3f800
`define GATE_PERIOD_BASE  5'h10

// Gate generator states
`define GEN_IDLE          2'h0
`define GEN_WAIT          2'h1
`define GEN_HIGH          2'h2
`define GEN_LOW           2'h3

`endif

// [main_timer_monitor.sv]
// Port checker for the multimode timer
`timescale 1ns/1ps
`default_nettype none
module main_timer_monitor (
  // Clock and reset
  input wire logic        clock_i,
  input wire logic        rstn_i,
  // Controls
  input wire logic [1:0]  start_control_i,
  input wire logic [1:0]  mode_select_i,
  input wire logic        counter_clear_i,
  input wire logic        other_timer_out_block_i,
  input wire logic        other_timer_out_i,
  // Results
  input wire logic [17:0] count_o,
  input wire logic        timer_irq_o,
  input wire logic        overflow_flag_o,
  input wire logic        counting_status_flag_o,
  input wire logic        shared_output_pin_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);

  a_stop_clears: assert property (start_control_i == 2'h0 |=> count_o == 18'h00000)
    else $error("count kept while stopped");
  a_reserved_holds: assert property (start_control_i == 2'h3 && !counter_clear_i |=> $stable(count_o))
    else $error("count moved on reserved code");
  a_clear_zeroes: assert property (counter_clear_i |=> count_o == 18'h00000)
    else $error("clear strobe left a count");
  a_irq_restart: assert property (timer_irq_o && $past(mode_select_i) == 2'h0 |-> count_o == 18'h00000)
    else $error("match did not restart count");
  a_status_mode: assert property (mode_select_i != 2'h3 |=> !counting_status_flag_o)
    else $error("status flag outside frequency mode");
  a_status_stop: assert property (start_control_i != 2'h2 |=> !counting_status_flag_o)
    else $error("status flag while stopped");
  a_ovf_sticky: assert property (overflow_flag_o && !counter_clear_i |=> overflow_flag_o)
    else $error("overflow flag dropped");
  a_pin_block: assert property ($past(rstn_i) && other_timer_out_block_i |=> !shared_output_pin_o)
    else $error("blocked pin driven");
  a_pin_pass: assert property ($past(rstn_i) && !other_timer_out_block_i
    |=> shared_output_pin_o == $past(other_timer_out_i))
    else $error("pin does not follow other timer");
endmodule // main_timer_monitor

bind main_timer main_timer_monitor u_mon (
  .clock_i(clock_i), .rstn_i(rstn_i), .start_control_i(start_control_i), .mode_select_i(mode_select_i),
  .counter_clear_i(counter_clear_i), .other_timer_out_block_i(other_timer_out_block_i),
  .other_timer_out_i(other_timer_out_i), .count_o(count_o), .timer_irq_o(timer_irq_o),
  .overflow_flag_o(overflow_flag_o), .counting_status_flag_o(counting_status_flag_o),
  .shared_output_pin_o(shared_output_pin_o));
`default_nettype wire

// [ext_pulse_source.sv]
// External count pulse and window gate source
`timescale 1ns/1ps
`default_nettype none
module ext_pulse_source (
  // Clock
  input  wire logic clock_i,
  // Pin drives
  output var logic  ext_count_o,
  output var logic  ext_gate_o
);
  initial begin
    ext_count_o = 1'b0;
    ext_gate_o  = 1'b0;
  end

  // Eight cycles high and nine low give a 17-cycle period, a rate of fc/17
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clock_i);
      ext_count_o <= 1'b1;
      repeat (8) @(posedge clock_i);
      ext_count_o <= 1'b0;
      repeat (8) @(posedge clock_i);
    end
  endtask

  task automatic level(input logic c, input logic g);
    @(posedge clock_i);
    ext_count_o <= c;
    ext_gate_o  <= g;
  endtask
endmodule // ext_pulse_source
`default_nettype wire

// [main_timer_tb_top.sv]
// Testbench for the multimode timer
`timescale 1ns/1ps
`default_nettype none
module main_timer_tb_top;
  logic        clock_i, rstn_i, clr, esel, blk, oth, wl, wm, wh, slow, dvb, fst;
  logic [1:0]  start, mode, gsrc;
  logic [2:0]  src;
  logic [3:0]  gset;
  logic [7:0]  wdata;
  wire  [17:0] count;
  wire         irq, ovf, stat, pin, ext_gate_input, egate;
  int          errors, checks_done, irqs, n, v;

  main_timer u_dut (.clock_i(clock_i), .rstn_i(rstn_i), .slow_mode_i(slow), .divider_source_bit_i(dvb),
    .fs_tick_i(fst), .start_control_i(start), .mode_select_i(mode), .source_clock_select_i(src),
    .counter_clear_i(clr), .irq_edge_select_i(esel), .gate_source_select_i(gsrc), .gate_clock_select_i(2'h0),
    .other_timer_out_block_i(blk), .gate_high_setting_i(gset), .gate_low_setting_i(gset),
    .cmp_wdata_i(wdata), .cmp_wr_low_i(wl), .cmp_wr_mid_i(wm), .cmp_wr_high_i(wh),
    .ext_count_input_i(ext_gate_input), .ext_gate_input_i(egate), .other_timer_out_i(oth), .count_o(count),
    .timer_irq_o(irq), .overflow_flag_o(ovf), .counting_status_flag_o(stat), .shared_output_pin_o(pin));

  ext_pulse_source u_src (.clock_i(clock_i), .ext_count_o(ext_gate_input), .ext_gate_o(egate));

  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  // Pulses last one cycle, so count them at every edge
  always @(posedge clock_i) if (irq === 1'b1) irqs <= irqs + 1;

  task stop_test;
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task tick(input int k);
    repeat (k) @(posedge clock_i);
    #1;
  endtask

  task go(input logic [1:0] s);
    @(posedge clock_i);
    start <= s;
    tick(1);
  endtask

  task cfg(input logic [1:0] m, input logic [2:0] s);
    go(2'h0);
    @(posedge clock_i);
    mode <= m;
    src <= s;
  endtask

  task cmpw(input logic [17:0] c, input logic lo_only);
    @(posedge clock_i);
    wdata <= c[7:0];
    wl <= 1'b1;
    @(posedge clock_i);
    wl <= 1'b0;
    if (!lo_only) begin
      wdata <= c[15:8];
      wm <= 1'b1;
      @(posedge clock_i);
      wm <= 1'b0;
      wdata <= {6'h00, c[17:16]};
      wh <= 1'b1;
      @(posedge clock_i);
      wh <= 1'b0;
    end
  endtask

  task gap(output int k);
    k = 0;
    do begin
      tick(1);
      k++;
    end while (irq !== 1'b1 && k < 3000);
  endtask

  // Cycles until the status flag reads the wanted level
  task wait_stat(input logic lvl, output int k);
    k = 0;
    do begin
      tick(1);
      k++;
    end while (stat !== lvl && k < 200);
  endtask

  // Software clear strobe, one cycle wide
  task pulse_clr;
    @(posedge clock_i);
    clr <= 1'b1;
    @(posedge clock_i);
    clr <= 1'b0;
    #1;
  endtask

  initial begin
    rstn_i = 1'b0; start = 2'h0; mode = 2'h0; gsrc = 2'h0; src = 3'h0; gset = 4'h0; clr = 1'b0;
    esel = 1'b0; blk = 1'b1; oth = 1'b0; wl = 1'b0; wm = 1'b0; wh = 1'b0; wdata = 8'h00;
    errors = 0; checks_done = 0; irqs = 0;
    slow = 1'b0;
    dvb = 1'b0;
    fst = 1'b0;
    repeat (8) @(posedge clock_i);
    rstn_i <= 1'b1;
    cmpw(18'h00003, 1'b0);
    go(2'h2);
    gap(n);
    gap(n);
    chk(n, 3);
    chk(count, 0);
    go(2'h3);
    v = count;
    tick(5);
    chk(count, v);
    go(2'h0);
    chk(count, 0);
    // Low byte alone must leave matching off
    cmpw(18'h00005, 1'b1);
    n = irqs;
    go(2'h2);
    tick(40);
    chk(irqs - n, 0);
    go(2'h0);
    cmpw(18'h00005, 1'b0);
    go(2'h2);
    gap(n);
    gap(n);
    chk(n, 5);
    pulse_clr;
    chk(count, 0);
    chk(ovf, 0);
    cfg(2'h0, 3'h7);
    cmpw(18'h00004, 1'b0);
    go(2'h2);
    n = irqs;
    u_src.pulses(10);
    tick(3);
    chk(irqs - n, 2);
    chk(count, 2);
    cfg(2'h3, 3'h7);
    cmpw(18'h3ffff, 1'b0);
    go(2'h2);
    n = irqs;
    u_src.level(1'b0, 1'b1);
    tick(3);
    chk(stat, 1);
    u_src.pulses(5);
    u_src.level(1'b0, 1'b0);
    tick(3);
    chk(count, 5);
    chk(stat, 0);
    chk(irqs - n, 1);
    u_src.pulses(3);
    tick(3);
    chk(count, 5);
    u_src.level(1'b0, 1'b1);
    u_src.pulses(2);
    u_src.level(1'b0, 1'b0);
    tick(3);
    chk(count, 7);
    pulse_clr;
    chk(count, 0);
    // Internal gate on fs taps: each phase is two gate ticks of 16 cycles
    cfg(2'h3, 3'h7);
    gsrc <= 2'h1;
    gset <= 4'he;
    dvb <= 1'b1;
    fst <= 1'b1;
    go(2'h2);
    wait_stat(1'b1, n);
    chk(n <= 17, 1);
    wait_stat(1'b0, n);
    chk(n, 32);
    wait_stat(1'b1, n);
    chk(n, 32);
    // Alternate tap C is fs/8 here, so three ticks take 24 cycles
    cfg(2'h0, 3'h4);
    cmpw(18'h00003, 1'b0);
    go(2'h2);
    gap(n);
    gap(n);
    chk(n, 24);
    // Pulse width with both-edge interrupts
    cfg(2'h2, 3'h0);
    esel <= 1'b1;
    gsrc <= 2'h0;
    go(2'h2);
    n = irqs;
    // Gate pin held high too: the status flag must stay off here
    u_src.level(1'b1, 1'b1);
    tick(20);
    chk(stat, 0);
    u_src.level(1'b0, 1'b0);
    tick(3);
    chk(irqs - n, 2);
    chk(count, 18'h00015);
    go(2'h0);
    u_src.level(1'b1, 1'b0);
    tick(3);
    n = irqs;
    go(2'h2);
    tick(2);
    chk(irqs - n, 1);
    go(2'h0);
    tick(2);
    chk(irqs - n, 2);
    u_src.level(1'b0, 1'b0);
    // Slow mode on fc ignores the low 11 compare bits: 2048, not 2053
    cfg(2'h0, 3'h0);
    slow <= 1'b1;
    cmpw(18'h00805, 1'b0);
    go(2'h2);
    gap(n);
    gap(n);
    chk(n, 2048);
    @(posedge clock_i);
    oth <= 1'b1;
    blk <= 1'b0;
    tick(2);
    chk(pin, 1);
    @(posedge clock_i);
    blk <= 1'b1;
    tick(2);
    chk(pin, 0);
    stop_test;
  end

  initial begin
    repeat (20000) @(posedge clock_i);
    errors++;
    stop_test;
  end
endmodule // main_timer_tb_top
`default_nettype wire
